/* rtl/pci_dma_arb_defines.svh */
`ifndef PCI_DMA_ARB_DEFINES_SVH
`define PCI_DMA_ARB_DEFINES_SVH

// register byte addresses
`define OFS_DMA_ACCESS_CONTROL   8'h44
`define OFS_MON_LATENCY_SLAVE    8'h48
`define OFS_MON_MASTER_TRANSFERS 8'h4c
`define OFS_POWER_MGMT_CAPS      8'h50

// dma access control fields
`define BIT_DMA_ACCESS_ENABLE 0
`define BIT_RX_PRIORITY_SEL   1
`define BIT_TX_PRIORITY_SEL   2
`define BIT_ONE_SHOT_DEBUG    3
`define RST_DMA_ACCESS_ENABLE 1'b1

// monitor units in bus clocks, and peak field width
`define BUS_LAT_UNIT_CLKS 16
`define IRQ_LAT_UNIT_CLKS 1024
`define OCCUPANCY_UNIT_CLKS 64
`define PEAK_WIDTH 8

// power management capability fields
`define CAP_WAKE_STATE_SUPPORT 5'b0_0100
`define CAP_DEEP_DOZE          1'b1
`define CAP_LIGHT_DOZE         1'b0
`define CAP_POWER_SPEC_VERSION 3'h1
`define CAP_NEXT_PTR           8'h00
`define CAP_POWER_ID           8'h01

// dma address space limit
`define ADDR_SPACE_LIMIT 33'h1_0000_0000

`endif

/* rtl/pci_dma_arb_pkg.sv */
package pci_dma_arb_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} bac_state_e;

	typedef struct packed {
		bac_state_e  st;
		logic        en;
		logic        pref_rx;
		logic        pref_tx;
		logic        single;
		logic        rx_gnt;
		logic        tx_gnt;
		logic [15:0] tgt;
		logic [5:0]  ini_pre;
		logic [15:0] ini;
		logic [5:0]  dp_pre;
		logic [15:0] dp;
		logic        pme_n;
		logic [31:0] rdata;
		logic        rvalid;
	} bac_s;

endpackage : pci_dma_arb_pkg

/* rtl/peak_tracker.sv */
`timescale 1ns/10ps
module peak_tracker #(
	parameter int UNIT  = 16,
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             clr,
	input  wire logic             waiting,
	output logic      [WIDTH-1:0] peak
);
	localparam int PW = $clog2(UNIT);

	typedef struct packed {
		logic [PW-1:0]    pre;
		logic [WIDTH-1:0] units;
		logic [WIDTH-1:0] peak;
	} peak_s;

	peak_s s_q;
	peak_s s_d;

	// refuse unit sizes the prescaler cannot count, at elaboration
	if (UNIT < 2 || (1 << PW) != UNIT || WIDTH < 1) begin : g_bad_params
		$error("peak_tracker: UNIT must be a power of two above one");
	end

	// count units while waiting, keep the highest seen
	always_comb begin
		s_d = s_q;
		if (waiting) begin
			s_d.pre = s_q.pre + 1'b1;
			if (&s_q.pre && !(&s_q.units))
				s_d.units = s_q.units + 1'b1;
		end else begin
			s_d.pre   = '0;
			s_d.units = '0;
		end
		if (s_q.units > s_q.peak)
			s_d.peak = s_q.units;
		if (clr)
			s_d = '0;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign peak = s_q.peak;

	property p_peak_hold;
		@(posedge sys_clk) disable iff (!nrst)
		!clr |=> s_q.peak >= $past(s_q.peak);
	endproperty
	a_peak_hold: assert property (p_peak_hold)
		else $error("peak fell without a clear");

endmodule : peak_tracker

/* rtl/dma_arbiter.sv */
`timescale 1ns/10ps
module dma_arbiter (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic rx_req,
	input  wire logic tx_req,
	input  wire logic pref_rx,
	input  wire logic pref_tx,
	input  wire logic take,
	output logic      pick_tx
);
	typedef struct packed {
		logic last_tx;
	} arb_s;

	arb_s s_q;
	arb_s s_d;

	// choose the channel that wins this cycle
	always_comb begin
		if (!tx_req)
			pick_tx = 1'b0;
		else if (!rx_req)
			pick_tx = 1'b1;
		else if (pref_tx)
			pick_tx = 1'b1;
		else if (pref_rx)
			pick_tx = 1'b0;
		else
			pick_tx = !s_q.last_tx;
	end

	// remember who was served for round robin
	always_comb begin
		s_d = s_q;
		if (take)
			s_d.last_tx = pick_tx;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule : dma_arbiter

/* rtl/pci_dma_arb_and_bus_monitor.sv */
// Contract
// - rx preference set and tx preference clear: receive requests win.
// - both preference bits clear: receive and transmit served round robin.
// - tx preference set: transmit requests win regardless of rx preference.
// - receive fifo above threshold forces effective rx preference to one; transmit fifo low forces effective tx preference to one.
// - enable resets to one; clear enable or master off ignores requests.
// - request with address plus size beyond 4 GByte clears enable.
// - write request misaligned or size not four-word multiple clears enable.
// - one-shot debug mode clears enable after each completed transfer.
// - monitor one bits 31:24 hold peak bus latency, 16-clock units.
// - monitor one bits 23:16 hold peak irq latency, 1024-clock units.
// - bits 15:0 count target cycles; cleared when data-phase count wraps.
// - monitor two 31:16 count initiator cycles per 64; cleared on wrap.
// - monitor two 15:0 count data phases per 64; cleared on initiator wrap.
// - capability bits 31:27 read constant wake state support list.
// - pme asserted on wake frame or link failure.
// - capability deep doze one, light doze zero, bits 24:22 zero.
// - capability bits 21, 20 and 19 read zero.
// - capability version field 18:16 reads one.
// - next pointer reads zero, capability id reads one.
`timescale 1ns/10ps
`include "pci_dma_arb_defines.svh"
module pci_dma_arb_and_bus_monitor
	import pci_dma_arb_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        global_master_enable,
	input  wire logic        rx_dma_req,
	input  wire logic [31:0] rx_addr,
	input  wire logic [15:0] rx_size,
	input  wire logic        tx_dma_req,
	input  wire logic [31:0] tx_addr,
	input  wire logic [15:0] tx_size,
	input  wire logic        dma_xfer_done,
	input  wire logic        rx_fifo_high,
	input  wire logic        tx_fifo_low,
	output logic             rx_dma_grant,
	output logic             tx_dma_grant,
	output logic             dma_access_enable,
	input  wire logic        bus_wait,
	input  wire logic        irq_wait,
	input  wire logic        devsel_as_target,
	input  wire logic        frame_as_initiator,
	input  wire logic        data_phase,
	input  wire logic        wake_frame,
	input  wire logic        link_fail,
	input  wire logic        pme_clear,
	output logic             pme_n
);
	bac_s s_q;
	bac_s s_d;

	logic                   pick_tx;
	logic                   eff_rx;
	logic                   eff_tx;
	logic                   live;
	logic                   any_req;
	logic                   fault;
	logic                   take;
	logic                   mon_clr;
	logic                   ini_wrap;
	logic                   dp_wrap;
	logic [`PEAK_WIDTH-1:0] bus_peak;
	logic [`PEAK_WIDTH-1:0] irq_peak;
	logic                   last_tx_h;

	// fault check on a request's address and size
	function automatic logic range_fault(input logic [31:0] a, input logic [15:0] n,
			input logic is_write);
		logic over;
		over = ({1'b0, a} + {17'h0_0000, n}) > `ADDR_SPACE_LIMIT;
		return over || (is_write && (a[1:0] != 2'b00 || n[3:0] != 4'h0));
	endfunction : range_fault

	// fixed capability word
	function automatic logic [31:0] caps_word();
		return {`CAP_WAKE_STATE_SUPPORT, `CAP_DEEP_DOZE, `CAP_LIGHT_DOZE, 3'b000,
			3'b000, `CAP_POWER_SPEC_VERSION, `CAP_NEXT_PTR, `CAP_POWER_ID};
	endfunction : caps_word

	// arbitration qualifiers
	assign eff_rx  = s_q.pref_rx | rx_fifo_high;
	assign eff_tx  = s_q.pref_tx | tx_fifo_low;
	assign live    = s_q.en & global_master_enable;
	assign any_req = rx_dma_req | tx_dma_req;
	assign fault   = pick_tx ? range_fault(tx_addr, tx_size, 1'b0)
			: range_fault(rx_addr, rx_size, 1'b1);
	assign take    = (s_q.st == ST_IDLE) && live && any_req && !fault;
	assign mon_clr = reg_wr && (reg_addr == `OFS_MON_LATENCY_SLAVE
			|| reg_addr == `OFS_MON_MASTER_TRANSFERS);
	assign ini_wrap = frame_as_initiator && (&s_q.ini_pre) && (&s_q.ini);
	assign dp_wrap  = data_phase && (&s_q.dp_pre) && (&s_q.dp);

	dma_arbiter u_arb (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.rx_req  (rx_dma_req),
		.tx_req  (tx_dma_req),
		.pref_rx (eff_rx),
		.pref_tx (eff_tx),
		.take    (take),
		.pick_tx (pick_tx)
	);

	peak_tracker #(.UNIT(`BUS_LAT_UNIT_CLKS), .WIDTH(`PEAK_WIDTH)) u_bus_peak (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.clr     (mon_clr),
		.waiting (bus_wait),
		.peak    (bus_peak)
	);

	peak_tracker #(.UNIT(`IRQ_LAT_UNIT_CLKS), .WIDTH(`PEAK_WIDTH)) u_irq_peak (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.clr     (mon_clr),
		.waiting (irq_wait),
		.peak    (irq_peak)
	);

	// next state of the whole block
	always_comb begin
		s_d        = s_q;
		s_d.rx_gnt = 1'b0;
		s_d.tx_gnt = 1'b0;
		s_d.rvalid = 1'b0;
		// software writes first so hardware clears win
		if (reg_wr && reg_addr == `OFS_DMA_ACCESS_CONTROL) begin
			s_d.en      = reg_wdata[`BIT_DMA_ACCESS_ENABLE];
			s_d.pref_rx = reg_wdata[`BIT_RX_PRIORITY_SEL];
			s_d.pref_tx = reg_wdata[`BIT_TX_PRIORITY_SEL];
			s_d.single  = reg_wdata[`BIT_ONE_SHOT_DEBUG];
		end
		// request acceptance and transfer tracking
		case (s_q.st)
			ST_IDLE: begin
				if (live && any_req) begin
					if (fault) begin
						s_d.en = 1'b0;
					end else begin
						s_d.st     = ST_BUSY;
						s_d.tx_gnt = pick_tx;
						s_d.rx_gnt = !pick_tx;
					end
				end
			end
			ST_BUSY: begin
				if (dma_xfer_done) begin
					s_d.st = ST_IDLE;
					if (s_q.single)
						s_d.en = 1'b0;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// bus occupancy and transfer counters
		s_d.tgt = s_q.tgt + {15'h0000, devsel_as_target};
		if (frame_as_initiator) begin
			s_d.ini_pre = s_q.ini_pre + 1'b1;
			if (&s_q.ini_pre)
				s_d.ini = s_q.ini + 1'b1;
		end
		if (data_phase) begin
			s_d.dp_pre = s_q.dp_pre + 1'b1;
			if (&s_q.dp_pre)
				s_d.dp = s_q.dp + 1'b1;
		end
		if (dp_wrap) begin
			s_d.tgt     = '0;
			s_d.ini     = '0;
			s_d.ini_pre = '0;
		end
		if (ini_wrap) begin
			s_d.dp     = '0;
			s_d.dp_pre = '0;
		end
		if (mon_clr) begin
			s_d.tgt     = '0;
			s_d.ini_pre = '0;
			s_d.ini     = '0;
			s_d.dp_pre  = '0;
			s_d.dp      = '0;
		end
		// wake signalling, event wins over clear
		if (pme_clear)
			s_d.pme_n = 1'b1;
		if (wake_frame || link_fail)
			s_d.pme_n = 1'b0;
		// register read data
		if (reg_rd) begin
			s_d.rvalid = 1'b1;
			if (reg_addr == `OFS_DMA_ACCESS_CONTROL)
				s_d.rdata = {28'h000_0000, s_q.single, s_q.pref_tx, s_q.pref_rx, s_q.en};
			else if (reg_addr == `OFS_MON_LATENCY_SLAVE)
				s_d.rdata = {bus_peak, irq_peak, s_q.tgt};
			else if (reg_addr == `OFS_MON_MASTER_TRANSFERS)
				s_d.rdata = {s_q.ini, s_q.dp};
			else if (reg_addr == `OFS_POWER_MGMT_CAPS)
				s_d.rdata = caps_word();
			else
				s_d.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q       <= '0;
			s_q.st    <= ST_IDLE;
			s_q.en    <= `RST_DMA_ACCESS_ENABLE;
			s_q.pme_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata         = s_q.rdata;
	assign reg_rvalid        = s_q.rvalid;
	assign rx_dma_grant      = s_q.rx_gnt;
	assign tx_dma_grant      = s_q.tx_gnt;
	assign dma_access_enable = s_q.en;
	assign pme_n             = s_q.pme_n;

	// last served channel, for checking round robin
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			last_tx_h <= 1'b0;
		else if (take)
			last_tx_h <= pick_tx;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	property p_rx_first;
		take && rx_dma_req && tx_dma_req && s_q.pref_rx && !eff_tx |=> rx_dma_grant;
	endproperty
	a_rx_first: assert property (p_rx_first)
		else $error("rx preference not honoured");

	property p_round_robin;
		take && rx_dma_req && tx_dma_req && !eff_rx && !eff_tx
			|=> (rx_dma_grant == $past(last_tx_h)) && (tx_dma_grant != $past(last_tx_h));
	endproperty
	a_round_robin: assert property (p_round_robin)
		else $error("round robin did not alternate");

	property p_tx_first;
		take && rx_dma_req && tx_dma_req && s_q.pref_tx |=> tx_dma_grant && !rx_dma_grant;
	endproperty
	a_tx_first: assert property (p_tx_first)
		else $error("tx preference not honoured");

	property p_fifo_force;
		take && rx_dma_req && tx_dma_req && rx_fifo_high && !eff_tx |=> rx_dma_grant;
	endproperty
	a_fifo_force: assert property (p_fifo_force)
		else $error("fifo level did not force rx first");

	property p_ignore;
		!(dma_access_enable && global_master_enable) |=> !rx_dma_grant && !tx_dma_grant;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("grant while disabled");

	property p_fault_clear;
		s_q.st == ST_IDLE && live && any_req && fault
			|=> !dma_access_enable && !rx_dma_grant && !tx_dma_grant;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("bad request left enable set");

	property p_misalign;
		s_q.st == ST_IDLE && live && rx_dma_req && !pick_tx && rx_addr[1:0] != 2'b00
			|=> !dma_access_enable;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned write left enable set");

	property p_one_shot;
		s_q.st == ST_BUSY && dma_xfer_done && s_q.single |=> !dma_access_enable;
	endproperty
	a_one_shot: assert property (p_one_shot)
		else $error("one-shot mode kept enable");

	property p_wrap;
		dp_wrap && !mon_clr |=> s_q.tgt == 16'h0000 && s_q.ini == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("wrap did not clear occupancy");

	property p_ini_wrap;
		ini_wrap |=> s_q.dp == 16'h0000;
	endproperty
	a_ini_wrap: assert property (p_ini_wrap)
		else $error("initiator wrap did not clear data phases");

	property p_pme;
		wake_frame || link_fail |=> !pme_n;
	endproperty
	a_pme: assert property (p_pme)
		else $error("pme not asserted");

	property p_caps;
		reg_rd && reg_addr == `OFS_POWER_MGMT_CAPS
			|=> reg_rvalid && reg_rdata == 32'h2401_0001;
	endproperty
	a_caps: assert property (p_caps)
		else $error("capability word wrong");

	property p_restart;
		mon_clr |=> s_q.tgt == 16'h0000 && s_q.dp == 16'h0000 ##1 bus_peak == 8'h00;
	endproperty
	a_restart: assert property (p_restart)
		else $error("monitor restart failed");

	c_rx_grant: cover property (rx_dma_grant);
	c_tx_grant: cover property (tx_dma_grant);
	c_fault:    cover property (s_q.st == ST_IDLE && live && any_req && fault);
	c_one_shot: cover property (s_q.st == ST_BUSY && dma_xfer_done && s_q.single);

endmodule : pci_dma_arb_and_bus_monitor

/* dv/dma_host_model.sv */
`timescale 1ns/10ps
module dma_host_model (
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       rx_dma_grant,
	input  wire logic       tx_dma_grant,
	input  wire logic [3:0] lat,
	output logic            dma_xfer_done
);
	logic       busy_q;
	logic [3:0] cnt_q;

	// each grant is answered by one completion pulse lat+1 cycles after the grant is seen
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busy_q        <= 1'b0;
			cnt_q         <= 4'h0;
			dma_xfer_done <= 1'b0;
		end else begin
			dma_xfer_done <= 1'b0;
			if (rx_dma_grant || tx_dma_grant) begin
				busy_q <= 1'b1;
				cnt_q  <= lat;
			end else if (busy_q) begin
				if (cnt_q == 4'h0) begin
					dma_xfer_done <= 1'b1; // transfer finished
					busy_q        <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule : dma_host_model

/* dv/tb_pci_dma_arb_and_bus_monitor.sv */
`timescale 1ns/10ps
module tb_pci_dma_arb_and_bus_monitor import pci_dma_arb_pkg::*;;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic        reg_rvalid, rx_dma_grant, tx_dma_grant, dma_access_enable, pme_n;
	logic        global_master_enable = 1'b1, dma_xfer_done;
	logic        rx_dma_req = 1'b0, tx_dma_req = 1'b0;
	logic [31:0] rx_addr = 32'h0000_0000, tx_addr = 32'h0000_0000;
	logic [15:0] rx_size = 16'h0000, tx_size = 16'h0000;
	logic        rx_fifo_high = 1'b0, tx_fifo_low = 1'b0, bus_wait = 1'b0, irq_wait = 1'b0;
	logic        devsel_as_target = 1'b0, frame_as_initiator = 1'b0, data_phase = 1'b0;
	logic        wake_frame = 1'b0, link_fail = 1'b0, pme_clear = 1'b0;
	logic [3:0]  lat = 4'h0;
	logic        last_tx = 1'b0; // round robin serves tx first after reset
	logic        e;
	logic [15:0] n;
	int          num_errors = 0;
	int          compares = 0;
	int          cyc = 0;
	int          seed = 32'h6bfaf00f;

	pci_dma_arb_and_bus_monitor pci_dma_arb_and_bus_monitor_inst (.sys_clk, .nrst, .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .global_master_enable,
		.rx_dma_req, .rx_addr, .rx_size, .tx_dma_req, .tx_addr, .tx_size, .dma_xfer_done,
		.rx_fifo_high, .tx_fifo_low, .rx_dma_grant, .tx_dma_grant, .dma_access_enable,
		.bus_wait, .irq_wait, .devsel_as_target, .frame_as_initiator, .data_phase,
		.wake_frame, .link_fail, .pme_clear, .pme_n);

	dma_host_model dma_host_model_inst (.sys_clk, .nrst, .rx_dma_grant, .tx_dma_grant, .lat,
		.dma_xfer_done);

	// clock and hang guard
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 12000) begin
			num_errors++;
			complete_run();
		end
	end

	task complete_run;
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// register read, answer one cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		chk({reg_rvalid, reg_rdata}, {1'b1, exp});
		reg_rd = 1'b0;
		@(negedge sys_clk);
	endtask : rd

	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		@(negedge sys_clk);
	endtask : wr

	// one request round; waits for the host completion when granted
	task dma(input logic r, input logic t, input logic [31:0] ra, input logic [31:0] ta,
		input logic [15:0] rs, input logic [15:0] ts, input logic er, input logic et);
		lat = 4'($random(seed));
		{rx_dma_req, tx_dma_req, rx_addr, tx_addr, rx_size, tx_size} = {r, t, ra, ta, rs, ts};
		@(negedge sys_clk);
		// grant stands for one cycle only, look while it is high
		chk({31'h0, rx_dma_grant, tx_dma_grant}, {31'h0, er, et});
		{rx_dma_req, tx_dma_req} = 2'b00;
		@(negedge sys_clk);
		if (er || et) begin
			last_tx = et;
			for (int i = 0; i < 40 && !dma_xfer_done; i++)
				@(negedge sys_clk);
			repeat (3) @(negedge sys_clk);
		end
	endtask : dma

	task hold(input int c);
		repeat (c) @(negedge sys_clk);
	endtask : hold

	function logic pick_tx(input logic pr, input logic pt, input logic fh);
		if (pt)
			return 1'b1;
		if (pr || fh)
			return 1'b0;
		return !last_tx;
	endfunction : pick_tx

	function logic [31:0] rnd_addr();
		return $random(seed) & 32'h0fff_fff0;
	endfunction : rnd_addr

	initial begin
		hold(16);
		nrst = 1'b1;
		@(negedge sys_clk);
		chk({31'h0, pme_n, dma_access_enable}, 33'h3);
		rd(8'h50, 32'h2401_0001);
		rd(8'h44, 32'h0000_0001);
		rd(8'h4c, 32'h0000_0000);
		rd(8'h54, 32'h0000_0000);
		// arbitration over every preference mix, twice for round robin
		for (int k = 0; k < 16; k++) begin
			wr(8'h44, {29'h0, k[1], k[0], 1'b1});
			rx_fifo_high = k[2];
			e = pick_tx(k[0], k[1], k[2]);
			dma(1, 1, rnd_addr(), rnd_addr(), 16'h0040, 16'($random(seed)), !e, e);
		end
		rx_fifo_high = 1'b0;
		// low transmit fifo forces tx over a set rx preference
		wr(8'h44, 32'h0000_0003);
		tx_fifo_low = 1'b1;
		dma(1, 1, rnd_addr(), rnd_addr(), 16'h0040, 16'h0040, 0, 1);
		tx_fifo_low = 1'b0;
		// requests ignored while disabled
		wr(8'h44, 32'h0000_0000);
		dma(1, 1, 32'h100, 32'h200, 16'h10, 16'h10, 0, 0);
		wr(8'h44, 32'h0000_0001);
		global_master_enable = 1'b0;
		dma(1, 1, 32'h100, 32'h200, 16'h10, 16'h10, 0, 0);
		global_master_enable = 1'b1;
		// address range and alignment faults
		dma(0, 1, 0, 32'hffff_ffe0, 0, 16'h0020, 0, 1);
		dma(0, 1, 0, 32'hffff_fff0, 0, 16'h0020, 0, 0);
		chk({32'h0, dma_access_enable}, 33'h0);
		wr(8'h44, 32'h0000_0001);
		dma(1, 0, 32'h0000_1002, 0, 16'h0040, 0, 0, 0);
		chk({32'h0, dma_access_enable}, 33'h0);
		wr(8'h44, 32'h0000_0001);
		dma(1, 0, 32'h0000_1000, 0, 16'h0018, 0, 0, 0);
		chk({32'h0, dma_access_enable}, 33'h0);
		wr(8'h44, 32'h0000_0001);
		dma(0, 1, 0, 32'h0000_1002, 0, 16'h0018, 0, 1);
		// one-shot debug mode
		wr(8'h44, 32'h0000_0009);
		dma(1, 0, rnd_addr(), 0, 16'h0040, 0, 1, 0);
		chk({32'h0, dma_access_enable}, 33'h0);
		rd(8'h44, 32'h0000_0008);
		// monitor counts and peaks
		wr(8'h48, 32'h0000_0000);
		n = 16'(($random(seed) & 32'h0000_007f) + 1);
		devsel_as_target = 1'b1;
		hold(n);
		devsel_as_target = 1'b0;
		{frame_as_initiator, data_phase} = 2'b11;
		hold(128 + ($random(seed) & 32'h3f));
		{frame_as_initiator, data_phase} = 2'b00;
		bus_wait = 1'b1;
		hold(16 * 3 + 5);
		bus_wait = 1'b0;
		hold(2);
		rd(8'h48, {8'd3, 8'd0, n});
		rd(8'h4c, 32'h0002_0002);
		irq_wait = 1'b1;
		hold(1024 * 2 + 10);
		irq_wait = 1'b0;
		bus_wait = 1'b1;
		hold(20);
		bus_wait = 1'b0;
		hold(2);
		rd(8'h48, {8'd3, 8'd2, n});
		wr(8'h4c, 32'hffff_ffff);
		rd(8'h48, 32'h0000_0000);
		rd(8'h4c, 32'h0000_0000);
		// wake events drive the wake signal low until cleared
		for (int k = 0; k < 2; k++) begin
			{wake_frame, link_fail} = {!k[0], k[0]};
			@(negedge sys_clk);
			{wake_frame, link_fail} = 2'b00;
			chk({32'h0, pme_n}, 33'h0);
			pme_clear = 1'b1;
			@(negedge sys_clk);
			pme_clear = 1'b0;
			chk({32'h0, pme_n}, 33'h1);
		end
		complete_run();
	end
endmodule : tb_pci_dma_arb_and_bus_monitor
